// >>> mahf_pkg.sv
package mahf_pkg;

   localparam int unsigned DATA_W        = 32;
   localparam int unsigned ADDR_W        = 8;

   // Register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_FILTER_CTRL   = 8'h01;
   localparam logic [ADDR_W-1:0] IDX_STATION_UPPER = 8'h02;
   localparam logic [ADDR_W-1:0] IDX_STATION_LOWER = 8'h03;
   localparam logic [ADDR_W-1:0] IDX_GROUP_UPPER   = 8'h04;
   localparam logic [ADDR_W-1:0] IDX_GROUP_LOWER   = 8'h05;
   localparam logic [1:0]        WORD_LSB_ZERO     = 2'h0;

   // Reset values and the station upper write mask
   localparam logic [DATA_W-1:0] STATION_UPPER_RST = 32'h0000FFFF;
   localparam logic [DATA_W-1:0] STATION_LOWER_RST = 32'h0FFFFFFF;
   localparam logic [DATA_W-1:0] GROUP_HASH_RST    = 32'h00000000;
   localparam logic [DATA_W-1:0] STATION_UPPER_MSK = 32'h0000FFFF;
   localparam logic [DATA_W-1:0] ZERO_WORD         = 32'h00000000;

   // Filter control word fields
   localparam int unsigned CTRL_ACCEPT_ALL_BIT = 0;
   localparam int unsigned CTRL_INIT_DONE_BIT  = 8;
   localparam int unsigned CTRL_LOADED_BIT     = 9;

   // Configuration memory byte addresses of the station address
   localparam logic [7:0] CFG_FIRST_BYTE = 8'h01;
   localparam logic [7:0] CFG_LOWER_LAST = 8'h04;
   localparam logic [7:0] CFG_UPPER_LO   = 8'h05;
   localparam logic [7:0] CFG_LAST_BYTE  = 8'h06;

   // Receive side
   localparam int unsigned STATION_BYTES = 6;
   localparam int unsigned HASH_W        = 6;
   localparam logic [31:0] CRC_POLY_REFL = 32'hEDB88320;
   localparam logic [31:0] CRC_INIT      = 32'hFFFFFFFF;

   typedef enum logic [1:0] {
      LD_IDLE = 2'b00,
      LD_REQ  = 2'b01,
      LD_WAIT = 2'b10,
      LD_DONE = 2'b11
   } mahf_load_state_type;

endpackage

// >>> mahf_word_reg.sv
`timescale 1ns/10ps
module mahf_word_reg
   import mahf_pkg::*;
#(
   parameter logic [DATA_W-1:0] RESET_VALUE = ZERO_WORD,
   parameter logic [DATA_W-1:0] WRITE_MASK  = 32'hFFFFFFFF
)(
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // Write port with byte enables
   input  wire logic              wr_en,
   input  wire logic [3:0]        wr_be,
   input  wire logic [DATA_W-1:0] wr_data,
   // Stored value
   output logic      [DATA_W-1:0] value_r
);

   logic [DATA_W-1:0] be_mask;
   logic [DATA_W-1:0] value_nxt;

   assign be_mask   = {{8{wr_be[3]}}, {8{wr_be[2]}}, {8{wr_be[1]}}, {8{wr_be[0]}}} & WRITE_MASK;
   assign value_nxt = wr_en ? ((value_r & ~be_mask) | (wr_data & be_mask)) : value_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value_r <= RESET_VALUE;
      end else begin
         value_r <= value_nxt;
      end
   end

endmodule

// >>> mahf_crc_hash.sv
`timescale 1ns/10ps
module mahf_crc_hash
   import mahf_pkg::*;
(
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // Byte stream
   input  wire logic              start,
   input  wire logic              byte_en,
   input  wire logic [7:0]        byte_in,
   // Running CRC and its hash index
   output logic      [31:0]       crc_r,
   output logic      [HASH_W-1:0] hash_idx
);

   logic [31:0] crc_seed;
   logic [31:0] crc_nxt;

   // Reflected CRC-32, least significant bit of each byte first
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
      end
      return r;
   endfunction

   assign crc_seed = start ? CRC_INIT : crc_r;
   assign crc_nxt  = byte_en ? crc_step(crc_seed, byte_in) : crc_r;
   assign hash_idx = crc_r[31:32-HASH_W]; // [RULE16]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_r <= CRC_INIT;
      end else begin
         crc_r <= crc_nxt;
      end
   end

endmodule

// >>> mahf_filter.sv
// Summary of operation
// RULE1: Upper register holds address 47:32, reset 0000FFFFh.
// RULE2: Lower register holds address 31:0, printed default.
// RULE3: Load both registers from programmed memory.
// RULE4: Memory bytes 5,6 fill upper bits 7:0,15:8.
// RULE5: Memory bytes 1..4 fill lower, byte1 lowest.
// RULE6: Software treats address undefined before load.
// RULE7: Host address writes accepted only after initialization.
// RULE8: Lower bits 7:0 match first received byte.
// RULE9: Leftmost address byte goes first on line.
// RULE10: Hash top bit picks register, rest bit.
// RULE11: Index 00000 low bit0, 11111 high bit31.
// RULE12: Selected table bit one accepts, zero rejects.
// RULE13: Accept-all setting passes every multicast frame.
// RULE14: High table bits 63:32, low 31:0, read/write.
// RULE15: Both table registers reset to zero.
// RULE16: Six-bit index from CRC of destination address.
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module mahf_filter
   import mahf_pkg::*;
(
   // APB slave
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output logic                   pready,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pslverr,
   // Configuration memory loader
   input  wire logic              cfg_present,
   input  wire logic              cfg_rd_ack,
   input  wire logic [7:0]        cfg_rd_data,
   output logic                   cfg_rd_req,
   output logic      [7:0]        cfg_rd_addr,
   // Receive byte stream
   input  wire logic              rx_sof,
   input  wire logic              rx_valid,
   input  wire logic [7:0]        rx_data,
   // Filter decision
   output logic                   rx_decision_valid,
   output logic                   rx_group_frame,
   output logic                   rx_station_match,
   output logic                   rx_group_accept
);

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   logic              access;
   logic              wr_access;
   logic [ADDR_W-1:0] reg_idx;
   logic              hit_ctrl;
   logic              hit_upper;
   logic              hit_lower;
   logic              hit_ghi;
   logic              hit_glo;
   logic              mapped;
   logic              pready_r;
   logic              pready_nxt;
   logic [DATA_W-1:0] prdata_r;
   logic [DATA_W-1:0] rd_mux;
   logic              pslverr_r;

   assign access    = psel & penable & pready_r;
   assign wr_access = access & pwrite & mapped;
   assign reg_idx   = paddr[ADDR_W+1:2];
   assign hit_ctrl  = (reg_idx == IDX_FILTER_CTRL);
   assign hit_upper = (reg_idx == IDX_STATION_UPPER);
   assign hit_lower = (reg_idx == IDX_STATION_LOWER);
   assign hit_ghi   = (reg_idx == IDX_GROUP_UPPER);
   assign hit_glo   = (reg_idx == IDX_GROUP_LOWER);
   assign mapped    = (paddr[1:0] == WORD_LSB_ZERO) & (hit_ctrl | hit_upper | hit_lower | hit_ghi | hit_glo);
   assign pready_nxt = psel & penable & ~pready_r;

   ////////////////////////////////////////////////////////////////////////////
   // Power-on load from configuration memory

   mahf_load_state_type ld_state_r;
   mahf_load_state_type ld_state_nxt;
   logic [7:0]          ld_addr_r;
   logic [7:0]          ld_addr_nxt;
   logic                cfg_rd_req_r;
   logic                loaded_r;
   logic                init_done;
   logic                ld_byte;
   logic [3:0]          ld_be;
   logic [DATA_W-1:0]   ld_word;
   logic                ld_upper;
   logic                ld_lower;

   assign init_done = (ld_state_r == LD_DONE);
   assign ld_byte   = (ld_state_r == LD_WAIT) & cfg_rd_ack;
   assign ld_upper  = ld_byte & (ld_addr_r >= CFG_UPPER_LO); // [RULE4]
   assign ld_lower  = ld_byte & (ld_addr_r <= CFG_LOWER_LAST); // [RULE5]
   assign ld_be     = ld_upper ? (4'h1 << 2'(ld_addr_r - CFG_UPPER_LO)) // [RULE4]
                               : (4'h1 << 2'(ld_addr_r - CFG_FIRST_BYTE)); // [RULE5]
   assign ld_word   = {4{cfg_rd_data}};

   always_comb begin
      ld_state_nxt = ld_state_r;
      ld_addr_nxt  = ld_addr_r;
      unique case (ld_state_r)
         LD_IDLE: begin
            ld_addr_nxt  = CFG_FIRST_BYTE;
            ld_state_nxt = cfg_present ? LD_REQ : LD_DONE; // [RULE3]
         end
         LD_REQ: begin
            ld_state_nxt = LD_WAIT;
         end
         LD_WAIT: begin
            if (cfg_rd_ack) begin
               ld_addr_nxt  = ld_addr_r + 8'h01;
               ld_state_nxt = (ld_addr_r == CFG_LAST_BYTE) ? LD_DONE : LD_REQ;
            end
         end
         LD_DONE: begin
            ld_state_nxt = LD_DONE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ld_state_r   <= LD_IDLE;
         ld_addr_r    <= 8'h00;
         cfg_rd_req_r <= 1'b0;
         loaded_r     <= 1'b0;
      end else begin
         ld_state_r   <= ld_state_nxt;
         ld_addr_r    <= ld_addr_nxt;
         cfg_rd_req_r <= (ld_state_nxt == LD_WAIT);
         loaded_r     <= loaded_r | (ld_byte & (ld_addr_r == CFG_LAST_BYTE));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [DATA_W-1:0] station_upper;
   logic [DATA_W-1:0] station_lower;
   logic [DATA_W-1:0] group_hash_upper;
   logic [DATA_W-1:0] group_hash_lower;
   logic              accept_all_group_frames_r;
   logic              host_addr_ok;
   logic              upper_we;
   logic              lower_we;
   logic [3:0]        upper_be;
   logic [3:0]        lower_be;
   logic [DATA_W-1:0] upper_wd;
   logic [DATA_W-1:0] lower_wd;
   logic [DATA_W-1:0] ctrl_word;

   assign host_addr_ok = wr_access & init_done; // [RULE7]
   assign upper_we = ld_upper | (host_addr_ok & hit_upper);
   assign lower_we = ld_lower | (host_addr_ok & hit_lower);
   assign upper_be = ld_upper ? ld_be : 4'hF;
   assign lower_be = ld_lower ? ld_be : 4'hF;
   assign upper_wd = ld_upper ? ld_word : pwdata;
   assign lower_wd = ld_lower ? ld_word : pwdata;

   mahf_word_reg #(
      .RESET_VALUE (STATION_UPPER_RST),
      .WRITE_MASK  (STATION_UPPER_MSK)
   ) u_station_upper ( // [RULE1]
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (upper_we),
      .wr_be   (upper_be),
      .wr_data (upper_wd),
      .value_r (station_upper)
   );

   mahf_word_reg #(
      .RESET_VALUE (STATION_LOWER_RST)
   ) u_station_lower ( // [RULE2]
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (lower_we),
      .wr_be   (lower_be),
      .wr_data (lower_wd),
      .value_r (station_lower)
   );

   mahf_word_reg #(
      .RESET_VALUE (GROUP_HASH_RST)
   ) u_group_hash_upper ( // [RULE14] [RULE15]
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (wr_access & hit_ghi),
      .wr_be   (4'hF),
      .wr_data (pwdata),
      .value_r (group_hash_upper)
   );

   mahf_word_reg #(
      .RESET_VALUE (GROUP_HASH_RST)
   ) u_group_hash_lower ( // [RULE14] [RULE15]
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (wr_access & hit_glo),
      .wr_be   (4'hF),
      .wr_data (pwdata),
      .value_r (group_hash_lower)
   );

   always_comb begin
      ctrl_word                      = ZERO_WORD;
      ctrl_word[CTRL_ACCEPT_ALL_BIT] = accept_all_group_frames_r;
      ctrl_word[CTRL_INIT_DONE_BIT]  = init_done;
      ctrl_word[CTRL_LOADED_BIT]     = loaded_r;
   end

   assign rd_mux = hit_ctrl  ? ctrl_word :
                   hit_upper ? station_upper :
                   hit_lower ? station_lower :
                   hit_ghi   ? group_hash_upper :
                   hit_glo   ? group_hash_lower : ZERO_WORD;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r                  <= 1'b0;
         prdata_r                  <= ZERO_WORD;
         pslverr_r                 <= 1'b0;
         accept_all_group_frames_r <= 1'b0;
      end else begin
         pready_r  <= pready_nxt;
         prdata_r  <= (pready_nxt & ~pwrite & mapped) ? rd_mux : ZERO_WORD;
         pslverr_r <= pready_nxt & ~mapped;
         if (wr_access & hit_ctrl) begin
            accept_all_group_frames_r <= pwdata[CTRL_ACCEPT_ALL_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Destination address filter

   logic [47:0]       station_addr;
   logic [2:0]        byte_cnt_r;
   logic [2:0]        byte_idx;
   logic              in_da;
   logic              da_byte;
   logic              match_r;
   logic              group_r;
   logic              decide_r;
   logic [7:0]        expect_byte;
   logic [63:0]       hash_table;
   logic [HASH_W-1:0] hash_idx;
   logic [DATA_W-1:0] hash_half;
   logic              hash_bit;
   logic              group_ok;
   logic              dec_valid_r;
   logic              dec_group_r;
   logic              dec_match_r;
   logic              dec_accept_r;

   // Lower bits 7:0 are the first byte on the wire
   assign station_addr = {station_upper[15:0], station_lower}; // [RULE8] [RULE9]
   assign byte_idx     = rx_sof ? 3'h0 : byte_cnt_r;
   assign in_da        = rx_sof | (byte_cnt_r != 3'h0);
   assign da_byte      = rx_valid & in_da;
   assign expect_byte  = station_addr[8*byte_idx +: 8]; // [RULE8]
   assign hash_table   = {group_hash_upper, group_hash_lower}; // [RULE14]
   assign hash_half    = hash_idx[HASH_W-1] ? group_hash_upper : group_hash_lower; // [RULE10]
   assign hash_bit     = hash_half[hash_idx[HASH_W-2:0]]; // [RULE10] [RULE11]
   assign group_ok     = accept_all_group_frames_r | hash_bit; // [RULE12] [RULE13]

   mahf_crc_hash u_crc_hash ( // [RULE16]
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (rx_sof),
      .byte_en  (da_byte),
      .byte_in  (rx_data),
      .crc_r    (),
      .hash_idx (hash_idx)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_cnt_r <= 3'h0;
         match_r    <= 1'b0;
         group_r    <= 1'b0;
         decide_r   <= 1'b0;
      end else begin
         decide_r <= da_byte & (byte_idx == 3'(STATION_BYTES - 1));
         if (da_byte) begin
            byte_cnt_r <= (byte_idx == 3'(STATION_BYTES - 1)) ? 3'h0 : byte_idx + 3'h1;
            match_r    <= ((byte_idx == 3'h0) | match_r) & (rx_data == expect_byte);
            group_r    <= (byte_idx == 3'h0) ? rx_data[0] : group_r;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_valid_r  <= 1'b0;
         dec_group_r  <= 1'b0;
         dec_match_r  <= 1'b0;
         dec_accept_r <= 1'b0;
      end else begin
         dec_valid_r  <= decide_r;
         if (decide_r) begin
            dec_group_r  <= group_r;
            dec_match_r  <= match_r;
            dec_accept_r <= group_r & group_ok; // [RULE12]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign pready            = pready_r;
   assign prdata            = prdata_r;
   assign pslverr           = pslverr_r;
   assign cfg_rd_req        = cfg_rd_req_r;
   assign cfg_rd_addr       = ld_addr_r;
   assign rx_decision_valid = dec_valid_r;
   assign rx_group_frame    = dec_group_r;
   assign rx_station_match  = dec_match_r;
   assign rx_group_accept   = dec_accept_r;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_last_byte_ack;
      ld_byte && (ld_addr_r == CFG_LAST_BYTE);
   endsequence

   sequence s_decision_pending;
      decide_r && group_r;
   endsequence

   a_upper_reserved_zero: assert property (station_upper[31:16] == 16'h0000) // [RULE1]
      else $error("station upper reserved bits not zero");

   a_lower_reset_val: assert property ((ld_state_r == LD_IDLE) |-> station_lower == STATION_LOWER_RST) // [RULE2]
      else $error("station lower not at reset value");

   a_load_completes: assert property (s_last_byte_ack |=> init_done && loaded_r) // [RULE3]
      else $error("load did not finish after last byte");

   a_absent_memory_skip: assert property ((ld_state_r == LD_IDLE) && !cfg_present |=> init_done && !cfg_rd_req) // [RULE3]
      else $error("missing memory did not skip load");

   a_upper_byte_load: assert property (ld_byte && ld_addr_r == CFG_LAST_BYTE |=> station_upper[15:8] == $past(cfg_rd_data)) // [RULE4]
      else $error("upper byte from memory byte 6 wrong");

   a_lower_byte_load: assert property (ld_byte && ld_addr_r == CFG_FIRST_BYTE |=> station_lower[7:0] == $past(cfg_rd_data)) // [RULE5]
      else $error("lower byte from memory byte 1 wrong");

   a_host_write_gate: assert property (wr_access && hit_lower && !init_done && !ld_byte |=> $stable(station_lower)) // [RULE7]
      else $error("address written before initialization");

   a_hash_select: assert property (s_decision_pending and !accept_all_group_frames_r
                                   |=> rx_group_accept == $past(hash_table[hash_idx])) // [RULE10] [RULE12]
      else $error("hash table bit selection wrong");

   a_pass_all_group: assert property (s_decision_pending and accept_all_group_frames_r |=> rx_group_accept) // [RULE13]
      else $error("accept-all did not pass group frame");

   a_table_reset_zero: assert property ((ld_state_r == LD_IDLE) |-> hash_table == 64'h0) // [RULE15]
      else $error("hash table not cleared at reset");

   a_apb_wait_state: assert property (psel && penable && !pready |=> pready ##1 !pready) // [RULE14]
      else $error("APB answer not one wait state");

endmodule

// >>> mahf_cfg_model.sv
`timescale 1ns/10ps
module mahf_cfg_model
   import mahf_pkg::*;
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Answer delay in cycles
   input  wire logic [3:0] ack_delay,
   // Loader read port
   input  wire logic       cfg_rd_req,
   input  wire logic [7:0] cfg_rd_addr,
   output logic            cfg_rd_ack,
   output logic      [7:0] cfg_rd_data
);
   logic [3:0] wait_r;
   logic [7:0] image [0:7];

   ////////////////////////////////////////////////////////////////////////////
   // Station address 12-34-56-78-9A-BC, byte 1 first on the wire
   initial begin
      image = '{8'h00, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, 8'h00};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data bus toggles whenever no byte is being answered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_r      <= 4'h0;
         cfg_rd_ack  <= 1'b0;
         cfg_rd_data <= 8'h5A;
      end else if (cfg_rd_ack) begin
         cfg_rd_ack  <= 1'b0;
         cfg_rd_data <= ~cfg_rd_data;
      end else if (cfg_rd_req && wait_r >= ack_delay) begin
         wait_r      <= 4'h0;
         cfg_rd_ack  <= 1'b1;
         cfg_rd_data <= image[cfg_rd_addr[2:0]];
      end else begin
         wait_r      <= cfg_rd_req ? wait_r + 4'h1 : 4'h0;
         cfg_rd_data <= ~cfg_rd_data;
      end
   end
endmodule

// >>> mahf_filter_test.sv
`timescale 1ns/10ps
module mahf_filter_test
   import mahf_pkg::*;
;
   localparam logic [47:0] STATION = 48'hBC9A78563412;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_data;
   logic        cfg_present, cfg_rd_ack, cfg_rd_req, rd_err;
   logic [7:0]  cfg_rd_data, cfg_rd_addr, rx_data;
   logic        rx_sof, rx_valid, rx_decision_valid, rx_group_frame, rx_station_match, rx_group_accept;
   logic [3:0]  ack_delay;
   int          failures = 0;
   int          num_checks = 0;
   int          cycles = 0;

   mahf_filter i_mahf_filter (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .cfg_present(cfg_present), .cfg_rd_ack(cfg_rd_ack), .cfg_rd_data(cfg_rd_data),
      .cfg_rd_req(cfg_rd_req), .cfg_rd_addr(cfg_rd_addr), .rx_sof(rx_sof), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_decision_valid(rx_decision_valid), .rx_group_frame(rx_group_frame),
      .rx_station_match(rx_station_match), .rx_group_accept(rx_group_accept));

   mahf_cfg_model i_mahf_cfg_model (
      .pclk(pclk), .presetn(presetn), .ack_delay(ack_delay), .cfg_rd_req(cfg_rd_req),
      .cfg_rd_addr(cfg_rd_addr), .cfg_rd_ack(cfg_rd_ack), .cfg_rd_data(cfg_rd_data));

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb_raw(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk_bit(pready, 1'b1);
   endtask

   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
      apb_raw(wr, {2'b00, idx, 2'b00}, d);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h00000000);
      chk_word(rd_data, exp);
      chk_bit(rd_err, 1'b0);
   endtask

   task automatic wait_ctrl(input logic [31:0] exp);
      int n;
      n = 0;
      do begin
         apb(1'b0, IDX_FILTER_CTRL, 32'h00000000);
         n++;
      end while (rd_data !== exp && n < 200);
      chk_word(rd_data, exp);
   endtask

   task automatic do_reset(input logic present, input logic [3:0] dly);
      @(posedge pclk);
      presetn     <= 1'b0;
      cfg_present <= present;
      ack_delay   <= dly;
      repeat (8) @(posedge pclk);
      presetn     <= 1'b1;
   endtask

   // Reflected CRC over the address, first byte and low bit first
   function automatic logic [5:0] hidx(input logic [47:0] w);
      logic [31:0] c;
      c = CRC_INIT;
      for (int i = 0; i < 48; i++) c = (c[0] ^ w[i]) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
      return c[31:26];
   endfunction

   function automatic logic [47:0] find(input logic [5:0] idx);
      logic [47:0] w;
      for (int j = 0; j < 65536; j++) begin
         w = {j[15:0], 32'h005E0001};
         if (hidx(w) == idx) return w;
      end
      return 48'h000000000000;
   endfunction

   task automatic frame(input logic [47:0] w, input logic grp, input logic mat, input logic acc);
      int n;
      for (int k = 0; k < 6; k++) begin
         @(posedge pclk);
         rx_valid <= 1'b1;
         rx_sof   <= (k == 0);
         rx_data  <= w[8*k +: 8];
      end
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_sof   <= 1'b0;
      n = 0;
      while (rx_decision_valid !== 1'b1 && n < 10) begin
         @(posedge pclk);
         n++;
      end
      chk_bit(rx_decision_valid, 1'b1);
      chk_bit(rx_group_frame, grp);
      chk_bit(rx_station_match, mat);
      chk_bit(rx_group_accept, acc);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults();
      do_reset(1'b0, 4'h0);
      wait_ctrl(32'h00000100);
      rd(IDX_STATION_UPPER, 32'h0000FFFF);
      rd(IDX_STATION_LOWER, 32'h0FFFFFFF);
      rd(IDX_GROUP_UPPER, 32'h00000000);
      rd(IDX_GROUP_LOWER, 32'h00000000);
      apb(1'b0, 8'h3F, 32'h00000000);
      chk_bit(rd_err, 1'b1);
      chk_word(rd_data, 32'h00000000);
      apb_raw(1'b0, 12'h009, 32'h00000000);
      chk_bit(rd_err, 1'b1);
   endtask

   task automatic t_host();
      apb(1'b1, IDX_STATION_UPPER, 32'hFFFF1234);
      rd(IDX_STATION_UPPER, 32'h00001234);
      apb(1'b1, IDX_STATION_LOWER, 32'hA55A0FF0);
      rd(IDX_STATION_LOWER, 32'hA55A0FF0);
      apb(1'b1, IDX_GROUP_UPPER, 32'h80000001);
      apb(1'b1, IDX_GROUP_LOWER, 32'h7FFFFFFE);
      rd(IDX_GROUP_UPPER, 32'h80000001);
      rd(IDX_GROUP_LOWER, 32'h7FFFFFFE);
      frame(48'h1234A55A0FF0, 1'b0, 1'b1, 1'b0);
   endtask

   task automatic t_load();
      do_reset(1'b1, 4'h8);
      apb(1'b1, IDX_STATION_LOWER, 32'h11111111);
      wait_ctrl(32'h00000300);
      rd(IDX_STATION_LOWER, 32'h78563412);
      rd(IDX_STATION_UPPER, 32'h0000BC9A);
      frame(STATION, 1'b0, 1'b1, 1'b0);
      frame(STATION ^ 48'h010000000000, 1'b0, 1'b0, 1'b0);
      frame(48'h123456789ABC, 1'b0, 1'b0, 1'b0);
   endtask

   task automatic t_hash();
      logic [5:0]  picks [0:3];
      logic [47:0] w;
      logic [31:0] m;
      picks = '{6'd0, 6'd63, 6'd31, 6'd32};
      for (int i = 0; i < 4; i++) begin
         w = find(picks[i]);
         m = 32'h00000001 << picks[i][4:0];
         apb(1'b1, IDX_GROUP_UPPER, picks[i][5] ? m : 32'h00000000);
         apb(1'b1, IDX_GROUP_LOWER, picks[i][5] ? 32'h00000000 : m);
         frame(w, 1'b1, 1'b0, 1'b1);
         apb(1'b1, IDX_GROUP_UPPER, picks[i][5] ? ~m : 32'hFFFFFFFF);
         apb(1'b1, IDX_GROUP_LOWER, picks[i][5] ? 32'hFFFFFFFF : ~m);
         frame(w, 1'b1, 1'b0, 1'b0);
      end
      apb(1'b1, IDX_FILTER_CTRL, 32'h00000001);
      frame(w, 1'b1, 1'b0, 1'b1);
      apb(1'b1, IDX_FILTER_CTRL, 32'h00000000);
      frame(w, 1'b1, 1'b0, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      presetn     = 1'b0;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = 12'h000;
      pwdata      = 32'h00000000;
      cfg_present = 1'b0;
      ack_delay   = 4'h0;
      rx_sof      = 1'b0;
      rx_valid    = 1'b0;
      rx_data     = 8'h00;
      t_defaults();
      t_host();
      t_load();
      t_hash();
      summarize();
   end
endmodule
